/* logic/alc_pkg.sv */
package alc_pkg;
    localparam int ALC_ENTRIES = 16;
    localparam int ALC_IDX_W = 4;
    localparam int ALC_TAG_W = 32;
    localparam int ALC_ST_W = 4;
    localparam int ALC_PTR_W = 12;
    localparam int ALC_RES_ST_LSB = 8;
    localparam int ALC_RES_HIT_BIT = 7;
    localparam int ALC_RES_IDX_LSB = 3;
    localparam int ALC_PTR_IDX_LSB = 6;
    localparam int ALC_PTR_CONST_LSB = 10;
    // Pointer load delay, counted in cycles after the lookup is taken
    localparam int ALC_PTR_DELAY = 3;

    typedef enum logic [2:0] {
        ALC_OP_NONE = 3'h0,
        ALC_OP_LOOKUP = 3'h1,
        ALC_OP_WRITE = 3'h2,
        ALC_OP_WRITE_STATE = 3'h3,
        ALC_OP_READ_TAG = 3'h4,
        ALC_OP_READ_STATE = 3'h5,
        ALC_OP_CLEAR = 3'h6
    } alc_op_t;

    typedef struct packed {
        alc_op_t op;
        logic [ALC_IDX_W-1:0] entry;
        logic [ALC_TAG_W-1:0] src;
        logic [ALC_ST_W-1:0] state;
        logic ptr_load;
        logic ptr_sel;
        logic [1:0] ptr_const;
    } alc_req_t;
endpackage

/* logic/alc_lookup_cam.sv */
`timescale 1ns/1ps
module alc_lookup_cam
    import alc_pkg::*;
(
    input wire logic clk_sys, // Engine clock
    input wire logic rst_n, // Engine reset, async, active low
    input wire logic req_valid, // Operation issued this cycle
    input wire alc_req_t req, // Operation and operands
    output logic res_valid_q, // Result word valid, one cycle
    output logic [ALC_TAG_W-1:0] res_data_q, // Result for the target register
    output logic [ALC_PTR_W-1:0] ptr0_q, // Local memory pointer 0
    output logic [ALC_PTR_W-1:0] ptr1_q, // Local memory pointer 1
    output logic ptr_upd_q // Pointer update became usable, one cycle
);
    // Storage has no reset: contents are defined only by software clear or writes
    logic [ALC_TAG_W-1:0] tag_q [ALC_ENTRIES];
    logic [ALC_ST_W-1:0] st_q [ALC_ENTRIES];
    // Usage order: slot 0 holds the least recent entry, slot 15 the most recent
    logic [ALC_IDX_W-1:0] ord_q [ALC_ENTRIES];
    // Flat copy of the usage order, so checks can compare the whole list at once
    wire [ALC_ENTRIES*ALC_IDX_W-1:0] ord_flat;

    wire is_lookup = req_valid && req.op == ALC_OP_LOOKUP;
    wire is_write = req_valid && req.op == ALC_OP_WRITE;
    wire is_wstate = req_valid && req.op == ALC_OP_WRITE_STATE;
    wire is_rtag = req_valid && req.op == ALC_OP_READ_TAG;
    wire is_rstate = req_valid && req.op == ALC_OP_READ_STATE;
    wire is_clear = req_valid && req.op == ALC_OP_CLEAR;

    logic [ALC_ENTRIES-1:0] match;
    genvar g;
    generate
        for (g = 0; g < ALC_ENTRIES; g++) begin : g_cmp
            assign match[g] = tag_q[g] == req.src;
        end
    endgenerate

    logic [ALC_IDX_W-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = 0; i < ALC_ENTRIES; i++) begin
            if (match[i]) begin
                hit_idx = ALC_IDX_W'(i);
            end
        end
    end

    wire hit = |match;
    wire [ALC_IDX_W-1:0] res_idx = hit ? hit_idx : ord_q[0];
    wire [ALC_ST_W-1:0] res_st = hit ? st_q[hit_idx] : '0;
    wire [ALC_TAG_W-1:0] lookup_word = {20'h0_0000, res_st, hit, res_idx, 3'h0};
    wire [ALC_TAG_W-1:0] rstate_word = {20'h0_0000, st_q[req.entry], 8'h00};
    wire [ALC_TAG_W-1:0] res_d = is_lookup ? lookup_word :
                                 is_rtag ? tag_q[req.entry] :
                                 is_rstate ? rstate_word : '0;
    wire res_v_d = is_lookup || is_rtag || is_rstate;

    // Entry to promote to most recent: a hit, or a full write
    wire promote = (is_lookup && hit) || is_write;
    wire [ALC_IDX_W-1:0] prom_idx = is_write ? req.entry : hit_idx;
    logic [ALC_IDX_W-1:0] prom_pos;
    always_comb begin
        prom_pos = '0;
        for (int i = 0; i < ALC_ENTRIES; i++) begin
            if (ord_q[i] == prom_idx) begin
                prom_pos = ALC_IDX_W'(i);
            end
        end
    end

    generate
        for (g = 0; g < ALC_ENTRIES; g++) begin : g_ent
            wire [ALC_IDX_W-1:0] pos = ALC_IDX_W'(g);
            assign ord_flat[g*ALC_IDX_W +: ALC_IDX_W] = ord_q[g];
            wire [ALC_IDX_W-1:0] ord_d = (g == ALC_ENTRIES - 1) ? prom_idx :
                                         (pos >= prom_pos) ? ord_q[g + 1 < ALC_ENTRIES ? g + 1 : g]
                                                           : ord_q[g];
            always_ff @(posedge clk_sys) begin
                if (is_clear) begin
                    tag_q[g] <= '0;
                    st_q[g] <= '0;
                    ord_q[g] <= pos;
                end else begin
                    if (is_write && req.entry == pos) begin
                        tag_q[g] <= req.src;
                    end
                    if ((is_write || is_wstate) && req.entry == pos) begin
                        st_q[g] <= req.state;
                    end
                    if (promote) begin
                        ord_q[g] <= ord_d;
                    end
                end
            end
        end
    endgenerate

    // Pointer value goes through a delay line matching the control-register write path
    wire [ALC_PTR_W-1:0] ptr_val = {req.ptr_const, res_idx, 6'h00};
    logic [ALC_PTR_DELAY-1:0] pd_v_q;
    logic [ALC_PTR_DELAY-1:0] pd_sel_q;
    logic [ALC_PTR_W-1:0] pd_val_q [ALC_PTR_DELAY];
    wire ld_now = pd_v_q[ALC_PTR_DELAY-1];
    wire [ALC_PTR_W-1:0] ld_val = pd_val_q[ALC_PTR_DELAY-1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_v_q <= '0;
            pd_sel_q <= '0;
        end else begin
            pd_v_q <= {pd_v_q[ALC_PTR_DELAY-2:0], is_lookup && req.ptr_load};
            pd_sel_q <= {pd_sel_q[ALC_PTR_DELAY-2:0], req.ptr_sel};
        end
    end

    always_ff @(posedge clk_sys) begin
        pd_val_q[0] <= ptr_val;
        for (int i = 1; i < ALC_PTR_DELAY; i++) begin
            pd_val_q[i] <= pd_val_q[i-1];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_q <= 1'b0;
            res_data_q <= '0;
            ptr0_q <= '0;
            ptr1_q <= '0;
            ptr_upd_q <= 1'b0;
        end else begin
            res_valid_q <= res_v_d;
            res_data_q <= res_d;
            ptr_upd_q <= ld_now;
            if (ld_now && !pd_sel_q[ALC_PTR_DELAY-1]) begin
                ptr0_q <= ld_val;
            end
            if (ld_now && pd_sel_q[ALC_PTR_DELAY-1]) begin
                ptr1_q <= ld_val;
            end
        end
    end

    // Checks
    sequence s_lookup_ld;
        is_lookup && req.ptr_load;
    endsequence

    a_lookup_zero_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_lookup |=> res_valid_q && res_data_q[31:12] == 20'h0_0000 && res_data_q[2:0] == 3'h0)
        else $error("lookup result has stray bits");
    a_miss_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_lookup && !hit |=> res_data_q[11:7] == 5'h00 && res_data_q[6:3] == $past(ord_q[0]))
        else $error("miss result wrong");
    a_hit_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_lookup && hit |=> res_data_q[7] && res_data_q[6:3] == $past(hit_idx))
        else $error("hit result wrong");
    a_miss_keeps_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_lookup && !hit |=> $stable(ord_flat))
        else $error("miss altered usage order");
    a_promote_mru: assert property (@(posedge clk_sys) disable iff (!rst_n)
        promote && !is_clear |=> ord_q[ALC_ENTRIES-1] == $past(prom_idx))
        else $error("promoted entry not most recent");
    a_read_no_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_rtag || is_rstate) |=> $stable(ord_flat))
        else $error("read altered usage order");
    a_state_read_fmt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rstate |=> res_data_q[31:12] == 20'h0_0000 && res_data_q[7:0] == 8'h00)
        else $error("state read format wrong");
    a_clear_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_clear |=> ord_q[0] == 4'h0 && ord_q[15] == 4'hF && tag_q[0] == 32'h0000_0000)
        else $error("clear did not initialise");
    a_ptr_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_lookup_ld |-> ##3 ld_now ##1 ptr_upd_q)
        else $error("pointer load delay wrong");
    a_ptr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ld_now |=> $stable(ptr0_q) && $stable(ptr1_q))
        else $error("pointer changed without load");
    // Storage is undefined until the first clear, so these only look at
    // entries that the engine has touched through an operation
    a_write_stores: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_write |=> tag_q[$past(req.entry)] == $past(req.src)
            && st_q[$past(req.entry)] == $past(req.state))
        else $error("full write did not store entry");
    a_wstate_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_wstate |=> $stable(ord_flat) && st_q[$past(req.entry)] == $past(req.state)
            && tag_q[$past(req.entry)] == $past(tag_q[req.entry]))
        else $error("state-only write disturbed tag or usage order");
    a_hit_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_lookup && hit |=> res_data_q[11:8] == $past(st_q[hit_idx]))
        else $error("hit result carries wrong state");
    a_rtag_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rtag |=> res_valid_q && res_data_q == $past(tag_q[req.entry]))
        else $error("tag read value wrong");
    a_rstate_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rstate |=> res_valid_q && res_data_q[11:8] == $past(st_q[req.entry]))
        else $error("state read value wrong");
    a_clear_all: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_clear |=> ord_flat == 64'hFEDC_BA98_7654_3210 && tag_q[15] == 32'h0000_0000
            && st_q[15] == 4'h0 && st_q[0] == 4'h0)
        else $error("clear left an entry or the usage order undefined");
    a_ptr_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_lookup_ld |-> ##4 ($past(req.ptr_sel, 4) ? ptr1_q : ptr0_q)
            == {$past(req.ptr_const, 4), $past(res_idx, 4), 6'h00})
        else $error("loaded pointer value wrong");
    a_ptr_no_spur: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ptr_upd_q |-> $past(is_lookup && req.ptr_load, 4))
        else $error("pointer update without a loading lookup");
endmodule // alc_lookup_cam

/* dv/alc_issue_model.sv */
`timescale 1ns/1ps
module alc_issue_model
    import alc_pkg::*;
(
    input wire logic clk_sys, // Engine clock
    output logic req_valid, // Operation issued
    output alc_req_t req // Operation and operands
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // Source and entry operands are scrambled once taken, so a stale value never passes for a held one
    task automatic issue(input alc_op_t o, input logic [3:0] e, input logic [31:0] s,
                         input logic [3:0] st, input logic [3:0] pl);
        @(negedge clk_sys);
        req_valid = 1'b1;
        req = '{op: o, entry: e, src: s, state: st, ptr_load: pl[3], ptr_sel: pl[2],
                ptr_const: pl[1:0]};
        @(negedge clk_sys);
        req_valid = 1'b0;
        req.src = ~req.src;
        req.entry = ~req.entry;
    endtask
endmodule // alc_issue_model

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import alc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid;
    logic res_valid_q;
    logic ptr_upd_q;
    alc_req_t req;
    logic [31:0] res_data_q;
    logic [11:0] ptr0_q;
    logic [11:0] ptr1_q;
    int err_total = 0;
    int n_compared = 0;
    localparam logic [31:0] MISS_KEY = 32'h0BAD_F00D;
    always #5 clk_sys = ~clk_sys;
    alc_issue_model alc_issue_model_inst (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));
    alc_lookup_cam alc_lookup_cam_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .res_valid_q(res_valid_q),
        .res_data_q(res_data_q), .ptr0_q(ptr0_q), .ptr1_q(ptr1_q), .ptr_upd_q(ptr_upd_q));
    task automatic final_report;
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lk(input logic [3:0] st, input logic hit, input logic [3:0] i);
        return {20'h0_0000, st, hit, i, 3'h0};
    endfunction
    function automatic logic [31:0] tg(input logic [3:0] e);
        return {28'hA5C3_000, e};
    endfunction
    // Issues one result-bearing operation and checks the one-cycle answer
    task automatic res_op(input alc_op_t o, input logic [3:0] e, input logic [31:0] s,
                          input logic [31:0] exp);
        alc_issue_model_inst.issue(o, e, s, 4'h0, 4'h0);
        chk({31'h0, res_valid_q}, 32'h1);
        chk(res_data_q, exp);
    endtask
    task automatic ptr_look(input logic [31:0] key, input logic [3:0] pl, input logic upd,
                            input logic [11:0] e0, input logic [11:0] e1);
        alc_issue_model_inst.issue(ALC_OP_LOOKUP, 4'h0, key, 4'h0, pl);
        repeat (2) @(negedge clk_sys);
        chk({31'h0, ptr_upd_q}, 32'h0);
        @(negedge clk_sys);
        chk({31'h0, ptr_upd_q}, {31'h0, upd});
        chk({ptr1_q, ptr0_q, 8'h00}, {e1, e0, 8'h00});
    endtask
    task automatic sc_clear;
        alc_issue_model_inst.issue(ALC_OP_CLEAR, 4'h0, 32'h0, 4'h0, 4'h0);
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h0));
        res_op(ALC_OP_READ_TAG, 4'hF, 32'h0, 32'h0);
        res_op(ALC_OP_READ_STATE, 4'hF, 32'h0, 32'h0);
    endtask
    task automatic sc_fill;
        for (int i = 0; i < 16; i++)
            alc_issue_model_inst.issue(ALC_OP_WRITE, 4'(i), tg(4'(i)), 4'(i), 4'h0);
        res_op(ALC_OP_READ_TAG, 4'h5, 32'h0, tg(4'h5));
        res_op(ALC_OP_LOOKUP, 4'h0, tg(4'h9), lk(4'h9, 1'b1, 4'h9));
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h0));
        res_op(ALC_OP_LOOKUP, 4'h0, tg(4'h0), lk(4'h0, 1'b1, 4'h0));
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h1));
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h1));
        res_op(ALC_OP_LOOKUP, 4'h0, 32'h0000_0000, lk(4'h0, 1'b0, 4'h1));
    endtask
    task automatic sc_state;
        alc_issue_model_inst.issue(ALC_OP_WRITE_STATE, 4'h1, 32'h0, 4'hC, 4'h0);
        chk({31'h0, res_valid_q}, 32'h0);
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h1));
        res_op(ALC_OP_READ_STATE, 4'h1, 32'h0, 32'h0000_0C00);
        res_op(ALC_OP_READ_TAG, 4'h1, 32'h0, tg(4'h1));
        res_op(ALC_OP_LOOKUP, 4'h0, MISS_KEY, lk(4'h0, 1'b0, 4'h1));
        res_op(ALC_OP_LOOKUP, 4'h0, tg(4'h1), lk(4'hC, 1'b1, 4'h1));
    endtask
    task automatic sc_ptr;
        ptr_look(tg(4'h7), 4'hA, 1'b1, 12'h9C0, 12'h000);
        ptr_look(tg(4'h3), 4'hD, 1'b1, 12'h9C0, 12'h4C0);
        ptr_look(tg(4'h4), 4'h7, 1'b0, 12'h9C0, 12'h4C0);
        ptr_look(MISS_KEY, 4'hB, 1'b1, 12'hC80, 12'h4C0);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(res_data_q, 32'h0000_0000);
        chk({8'h00, ptr1_q, ptr0_q}, 32'h0000_0000);
        chk({30'h0, res_valid_q, ptr_upd_q}, 32'h0000_0000);
        rst_n = 1'b1;
        sc_clear();
        sc_fill();
        sc_state();
        sc_ptr();
        final_report();
    end
endmodule // tb
